// ---- inc/load_merge_pkg.sv ----
// constants and carrier types of the unaligned word load merge block
package load_merge_pkg;
   // ****************************************
   // opcodes and access types
   // ****************************************
   localparam logic [5:0] OPC_LEFT  = 6'h22;
   localparam logic [5:0] OPC_RIGHT = 6'h26;
   localparam logic [5:0] OPC_UWORD = 6'h2F;
   localparam logic [2:0] TYPE_WORD = 3'h3;
   localparam logic [2:0] TYPE_MAX  = 3'h3;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CLEAR  = 4'h8;
   localparam logic [3:0] ADDR_ENABLE = 4'hC;
   localparam logic [4:0] CTRL_RESET  = 5'h00;
   localparam logic [4:0] EV_RESET    = 5'h00;
   // status bit positions
   localparam int EV_ADDR    = 0;
   localparam int EV_RESV    = 1;
   localparam int EV_REFILL  = 2;
   localparam int EV_INVALID = 3;
   localparam int EV_BUS     = 4;
   localparam int EV_W       = 5;

   typedef enum logic [2:0] {
      EXC_NONE    = 3'b000,
      EXC_ADDR    = 3'b001,
      EXC_RESV    = 3'b010,
      EXC_REFILL  = 3'b011,
      EXC_INVALID = 3'b100,
      EXC_BUS     = 3'b101
   } exc_t;

   typedef enum logic [1:0] {
      OP_LEFT  = 2'b00,
      OP_RIGHT = 2'b01,
      OP_UWORD = 2'b10
   } op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } state_t;

   // mode bits, ctrl register layout from bit 4 downward
   typedef struct packed {
      logic user_byte_order_swap;
      logic cpu_byte_order_big;
      logic memory_byte_order_big;
      logic kernel_mode;
      logic mode64;
   } mode_t;

   typedef struct packed {
      logic [63:0] virtual_address;
      logic [2:0]  access_type;
      logic [2:0]  offset;
   } mem_req_t;

   typedef struct packed {
      logic [63:0] data;
      logic        tlb_refill;
      logic        tlb_invalid;
      logic        bus_error;
   } mem_rsp_t;
endpackage

// ---- rtl/unaligned_word_load_merge.sv ----
// load alignment, merge and exception logic for partial and unsigned loads
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module unaligned_word_load_merge (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic                    issue_valid,
   input  wire logic [31:0]             issue_instr,
   input  wire logic [63:0]             issue_base_value,
   input  wire logic [63:0]             issue_target_value,
   output      logic                    busy,
   output      logic                    mem_req_valid,
   output      load_merge_pkg::mem_req_t mem_req,
   input  wire logic                    mem_rsp_valid,
   input  wire load_merge_pkg::mem_rsp_t mem_rsp,
   output      logic                    wb_valid,
   output      logic [4:0]              wb_index,
   output      logic [63:0]             wb_data,
   output      logic                    exc_valid,
   output      load_merge_pkg::exc_t    exc_code,
   input  wire logic [3:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output      logic [31:0]             reg_rdata,
   output      logic                    irq
);
   import load_merge_pkg::*;
   // ****************************************
   // decode and address forming
   // ****************************************
   state_t      state_reg;
   mode_t       ctrl_reg;
   mode_t       mode_reg;
   op_t         op_reg;
   logic [63:0] va_reg;
   logic [63:0] target_reg;
   logic [1:0]  byte_reg;
   logic        word_reg;
   logic [EV_W-1:0] status_reg;
   logic [EV_W-1:0] enable_reg;
   logic [EV_W-1:0] ev_set;
   logic [5:0]  opcode;
   logic [4:0]  base_f;
   logic [4:0]  target_register;
   logic [63:0] sum;
   logic [63:0] virtual_address;
   logic        is_left;
   logic        is_right;
   logic        is_uword;
   logic        known;
   logic        take;
   logic        resv;
   logic        misalign;
   logic [63:0] target_fwd;
   logic [1:0]  byte_idx;
   logic [2:0]  phys_low;
   assign opcode          = issue_instr[31:26];
   assign base_f          = issue_instr[25:21];
   assign target_register = issue_instr[20:16];
   assign is_left  = opcode == OPC_LEFT;
   assign is_right = opcode == OPC_RIGHT;
   assign is_uword = opcode == OPC_UWORD;
   assign known    = is_left | is_right | is_uword;
   assign take     = (state_reg == ST_IDLE) & issue_valid & known;
   // sign-extended offset plus base; 32-bit mode wraps to a word
   assign sum = issue_base_value
              + {{48{issue_instr[15]}}, issue_instr[15:0]};
   assign virtual_address = ctrl_reg.mode64 ? sum
                          : {{32{sum[31]}}, sum[31:0]};
   // only the zero-extended load checks mode and alignment
   assign resv     = is_uword & ~ctrl_reg.mode64
                   & ~ctrl_reg.kernel_mode;
   assign misalign = is_uword
                   & (virtual_address[1:0] != 2'b00);
   // bypass the load result written back in the same cycle
   assign target_fwd = (wb_valid & (wb_index == target_register))
                     ? wb_data : issue_target_value;
   assign byte_idx = virtual_address[1:0]
                   ^ {2{ctrl_reg.cpu_byte_order_big}};
   // no translation here, so the low physical bits are the virtual ones, inverted when user_byte_order_swap is set
   assign phys_low = virtual_address[2:0]
                   ^ {3{ctrl_reg.user_byte_order_swap}};
   // ****************************************
   // request sequencing
   // ****************************************
   // one load in flight; faults found at decode answer next cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg     <= ST_IDLE;
         mem_req_valid <= 1'b0;
         mem_req       <= '0;
         busy          <= 1'b0;
      end else begin
         mem_req_valid <= 1'b0;
         if (state_reg == ST_IDLE) begin
            if (take & ~resv & ~misalign) begin
               state_reg     <= ST_WAIT;
               busy          <= 1'b1;
               mem_req_valid <= 1'b1;
               mem_req.virtual_address <= virtual_address;
               if (is_right) begin
                  mem_req.access_type <= TYPE_MAX
                                       - {1'b0, byte_idx};
                  mem_req.offset <= ctrl_reg.memory_byte_order_big
                                  ? 3'h0 : phys_low;
               end else if (is_left) begin
                  mem_req.access_type <= {1'b0, byte_idx};
                  mem_req.offset <= ctrl_reg.memory_byte_order_big
                                  ? phys_low
                                  : {phys_low[2], 2'b00};
               end else begin
                  mem_req.access_type <= TYPE_WORD;
                  mem_req.offset      <= phys_low;
               end
            end
         end else if (mem_rsp_valid) begin
            state_reg <= ST_IDLE;
            busy      <= 1'b0;
         end
      end
   end
   // operand capture at acceptance
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_reg   <= OP_LEFT;
         va_reg   <= '0;
         target_reg <= '0;
         byte_reg <= 2'b00;
         word_reg <= 1'b0;
         mode_reg <= CTRL_RESET;
         wb_index <= 5'h00;
      end else if (take) begin
         op_reg   <= is_right ? OP_RIGHT : is_left ? OP_LEFT : OP_UWORD;
         va_reg   <= virtual_address;
         target_reg <= target_fwd;
         byte_reg <= byte_idx;
         word_reg <= virtual_address[2] ^ ctrl_reg.cpu_byte_order_big;
         mode_reg <= ctrl_reg;
         wb_index <= target_register;
      end
   end
   // ****************************************
   // byte lane merge
   // ****************************************
   logic [31:0] mem_word;
   logic [31:0] rsh;
   logic [31:0] lsh;
   logic [31:0] right_w;
   logic [31:0] left_w;
   logic [63:0] merged;
   logic        fault;
   // only the aligned word holding the start byte is used
   assign mem_word = word_reg ? mem_rsp.data[63:32]
                              : mem_rsp.data[31:0];
   assign rsh = mem_word >> {byte_reg, 3'b000};
   assign lsh = mem_word << {~byte_reg, 3'b000};
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         logic [2:0] pos;
         assign pos = 3'(g) + {1'b0, byte_reg};
         // right part: lanes up to the word's top come from memory
         assign right_w[8*g+:8] = (pos <= 3'h3) ? rsh[8*g+:8]
                                : target_reg[8*g+:8];
         // left part: lanes from the top down come from memory
         assign left_w[8*g+:8]  = (pos >= 3'h3) ? lsh[8*g+:8]
                                : target_reg[8*g+:8];
      end
   endgenerate
   always_comb begin
      merged = '0;
      case (op_reg)
         OP_RIGHT: merged = mode_reg.mode64
                          ? {{32{right_w[31]}}, right_w}
                          : {target_reg[63:32], right_w};
         OP_LEFT:  merged = mode_reg.mode64
                          ? {{32{left_w[31]}}, left_w}
                          : {target_reg[63:32], left_w};
         OP_UWORD: merged = {32'h0000_0000, mem_word};
         default:  merged = '0;
      endcase
   end
   assign fault = mem_rsp.tlb_refill | mem_rsp.tlb_invalid
                | mem_rsp.bus_error;
   // ****************************************
   // write back and exceptions
   // ****************************************
   // faults win over the register write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_valid  <= 1'b0;
         wb_data   <= '0;
         exc_valid <= 1'b0;
         exc_code  <= EXC_NONE;
      end else begin
         wb_valid  <= 1'b0;
         exc_valid <= 1'b0;
         exc_code  <= EXC_NONE;
         if (take & resv) begin
            exc_valid <= 1'b1;
            exc_code  <= EXC_RESV;
         end else if (take & misalign) begin
            exc_valid <= 1'b1;
            exc_code  <= EXC_ADDR;
         end else if ((state_reg == ST_WAIT) & mem_rsp_valid) begin
            if (fault) begin
               exc_valid <= 1'b1;
               exc_code  <= mem_rsp.tlb_refill  ? EXC_REFILL
                          : mem_rsp.tlb_invalid ? EXC_INVALID
                          : EXC_BUS;
            end else begin
               wb_valid <= 1'b1;
               wb_data  <= merged;
            end
         end
      end
   end
   // ****************************************
   // register slave and interrupt
   // ****************************************
   assign ev_set = {EV_W{1'b0}}
      | ((take & misalign & ~resv) ? EV_W'(1) << EV_ADDR : '0)
      | ((take & resv) ? EV_W'(1) << EV_RESV : '0)
      | (((state_reg == ST_WAIT) & mem_rsp_valid & mem_rsp.tlb_refill)
         ? EV_W'(1) << EV_REFILL : '0)
      | (((state_reg == ST_WAIT) & mem_rsp_valid & mem_rsp.tlb_invalid)
         ? EV_W'(1) << EV_INVALID : '0)
      | (((state_reg == ST_WAIT) & mem_rsp_valid & mem_rsp.bus_error)
         ? EV_W'(1) << EV_BUS : '0);
   // sticky status: a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= EV_RESET;
      end else begin
         status_reg <= (status_reg
            & ~((reg_wr & (reg_addr == ADDR_CLEAR))
                ? reg_wdata[EV_W-1:0] : '0)) | ev_set;
      end
   end
   // ctrl and enable; mode changes apply to the next accepted load
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg   <= CTRL_RESET;
         enable_reg <= EV_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CTRL) begin
            ctrl_reg <= reg_wdata[4:0];
         end
         if (reg_addr == ADDR_ENABLE) begin
            enable_reg <= reg_wdata[EV_W-1:0];
         end
      end
   end
   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
         irq       <= 1'b0;
      end else begin
         reg_rdata <= '0;
         irq       <= |(status_reg & enable_reg);
         if (reg_rd) begin
            case (reg_addr)
               ADDR_CTRL:   reg_rdata <= {27'h0, ctrl_reg};
               ADDR_STATUS: reg_rdata <= {27'h0, status_reg};
               ADDR_ENABLE: reg_rdata <= {27'h0, enable_reg};
               default:     reg_rdata <= '0;
            endcase
         end
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   sequence s_accept_ok;
      take & ~resv & ~misalign;
   endsequence
   sequence s_request;
      mem_req_valid & busy;
   endsequence
   property p_accept_req;
      @(posedge clk) disable iff (!reset_n)
      s_accept_ok |=> s_request;
   endproperty
   a_accept_req: assert property (p_accept_req)
      else $error("accepted load issued no request");
   property p_no_align_partial;
      @(posedge clk) disable iff (!reset_n)
      (take & ~is_uword) |=> !(exc_valid & (exc_code == EXC_ADDR));
   endproperty
   a_no_align_partial: assert property (p_no_align_partial)
      else $error("partial load raised address error");
   property p_uword_misalign;
      @(posedge clk) disable iff (!reset_n)
      (take & is_uword & ~resv & (virtual_address[1:0] != 2'b00))
      |=> exc_valid & (exc_code == EXC_ADDR) & !wb_valid & !busy;
   endproperty
   a_uword_misalign: assert property (p_uword_misalign)
      else $error("misaligned word load not trapped");
   property p_uword_resv;
      @(posedge clk) disable iff (!reset_n)
      (take & is_uword & ~ctrl_reg.mode64 & ~ctrl_reg.kernel_mode)
      |=> exc_valid & (exc_code == EXC_RESV);
   endproperty
   a_uword_resv: assert property (p_uword_resv)
      else $error("word load in user mode not trapped");
   property p_uword_zero;
      @(posedge clk) disable iff (!reset_n)
      (wb_valid & (op_reg == OP_UWORD)) |-> (wb_data[63:32] == 32'h0);
   endproperty
   a_uword_zero: assert property (p_uword_zero)
      else $error("word load upper half not zero");
   property p_right_sext;
      @(posedge clk) disable iff (!reset_n)
      (wb_valid & (op_reg == OP_RIGHT) & mode_reg.mode64)
      |-> (wb_data[63:32] == {32{wb_data[31]}});
   endproperty
   a_right_sext: assert property (p_right_sext)
      else $error("right part result not sign-extended");
   property p_fault_nowrite;
      @(posedge clk) disable iff (!reset_n)
      ((state_reg == ST_WAIT) & mem_rsp_valid & fault)
      |=> exc_valid & !wb_valid;
   endproperty
   a_fault_nowrite: assert property (p_fault_nowrite)
      else $error("memory fault let the write through");
   property p_right_type;
      @(posedge clk) disable iff (!reset_n)
      (mem_req_valid & (op_reg == OP_RIGHT))
      |-> (mem_req.access_type == 3'(3 - byte_reg));
   endproperty
   a_right_type: assert property (p_right_type)
      else $error("right part access type wrong");
   property p_right_big_off;
      @(posedge clk) disable iff (!reset_n)
      (mem_req_valid & (op_reg == OP_RIGHT)
       & mode_reg.memory_byte_order_big) |-> (mem_req.offset == 3'h0);
   endproperty
   a_right_big_off: assert property (p_right_big_off)
      else $error("big memory offset not cleared");
   property p_right_le_off;
      @(posedge clk) disable iff (!reset_n)
      (mem_req_valid & (op_reg == OP_RIGHT)
       & ~mode_reg.memory_byte_order_big)
      |-> (mem_req.offset
           == (va_reg[2:0] ^ {3{mode_reg.user_byte_order_swap}}));
   endproperty
   a_right_le_off: assert property (p_right_le_off)
      else $error("little memory right offset wrong");
   property p_left_le;
      @(posedge clk) disable iff (!reset_n)
      (mem_req_valid & (op_reg == OP_LEFT)
       & ~mode_reg.memory_byte_order_big)
      |-> (mem_req.offset[1:0] == 2'b00)
          & (mem_req.access_type == {1'b0, byte_reg});
   endproperty
   a_left_le: assert property (p_left_le)
      else $error("little memory left request wrong");
   property p_forward;
      @(posedge clk) disable iff (!reset_n)
      (take & wb_valid & (wb_index == target_register))
      |=> (target_reg == $past(wb_data));
   endproperty
   a_forward: assert property (p_forward)
      else $error("target value not bypassed");
endmodule

// ---- tb/mem_model.sv ----
// memory side model answering load requests after a chosen delay
`timescale 1ns/1ps
module mem_model #(
   parameter logic [63:0] DWORD = 64'h71E2D3C4B5A69788
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     mem_req_valid,
   input  wire logic [3:0]               delay,
   input  wire logic [2:0]               fault,
   output      logic                     mem_rsp_valid,
   output      load_merge_pkg::mem_rsp_t mem_rsp
);
   import load_merge_pkg::*;
   logic [3:0] cnt_reg;
   logic       pend_reg;
   // outside the answer cycle the data toggles, so stale bytes never match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg       <= 4'h0;
         pend_reg      <= 1'b0;
         mem_rsp_valid <= 1'b0;
         mem_rsp       <= '0;
      end else begin
         mem_rsp_valid <= 1'b0;
         mem_rsp       <= ~mem_rsp;
         if (mem_req_valid) begin
            pend_reg <= 1'b1;
            cnt_reg  <= delay;
         end else if (pend_reg && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
         end else if (pend_reg) begin
            pend_reg      <= 1'b0;
            mem_rsp_valid <= 1'b1;
            mem_rsp       <= {DWORD, fault};
         end
      end
   end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the unaligned word load merge block
`timescale 1ns/1ps
module tb_top;
   import load_merge_pkg::*;
   // ************
   // signals
   // ************
   localparam logic [63:0] DW = 64'h71E2D3C4B5A69788;
   logic        clk, reset_n, issue_valid, reg_wr, reg_rd, busy, irq;
   logic        mem_req_valid, mem_rsp_valid, wb_valid, exc_valid;
   logic [31:0] issue_instr, reg_wdata, reg_rdata;
   logic [63:0] base_v, tgt_v, wb_data, got_data;
   mem_req_t    mem_req, req;
   mem_rsp_t    mem_rsp;
   exc_t        exc_code;
   logic [4:0]  wb_index, ctrl;
   logic [3:0]  reg_addr, delay, got_exc;
   logic [2:0]  fault;
   logic        seen, got_wb;
   int          errors, total_checks;
   logic [4:0]  modes [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h10, 5'h08, 5'h1D};
   logic [5:0]  opcs [3] = '{OPC_RIGHT, OPC_LEFT, OPC_UWORD};

   unaligned_word_load_merge unaligned_word_load_merge_inst (
      .clk(clk), .reset_n(reset_n), .issue_valid(issue_valid),
      .issue_instr(issue_instr), .issue_base_value(base_v),
      .issue_target_value(tgt_v), .busy(busy),
      .mem_req_valid(mem_req_valid), .mem_req(mem_req),
      .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp),
      .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
      .exc_valid(exc_valid), .exc_code(exc_code), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));
   mem_model #(.DWORD(DW)) mem_model_inst (
      .clk(clk), .reset_n(reset_n), .mem_req_valid(mem_req_valid),
      .delay(delay), .fault(fault), .mem_rsp_valid(mem_rsp_valid),
      .mem_rsp(mem_rsp));

   // ************
   // tasks
   // ************
   task check(input string name, input logic [63:0] exp,
              input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // the single place where the run ends
   task results;
      if (errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task reg_chk(input string name, input logic [3:0] a,
                input logic [31:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(name, 64'(exp), 64'(reg_rdata));
   endtask
   // base 1_0000_1000 plus offset -16+va, target register 9
   task issue(input logic [5:0] opc, input logic [2:0] va,
              input logic [63:0] tv);
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_instr <= {opc, 5'd3, 5'd9, 13'h1FFE, va};
      tgt_v       <= tv;
      @(posedge clk);
      issue_valid <= 1'b0;
   endtask
   // bounded wait for the result pulse, noting any request on the way
   task finish;
      int n;
      seen = 1'b0;
      for (n = 0; n < 40; n++) begin
         #1;
         if (mem_req_valid) begin
            seen = 1'b1;
            req  = mem_req;
         end
         if (wb_valid || exc_valid) break;
         @(posedge clk);
      end
      got_wb   = wb_valid;
      got_exc  = {exc_valid, exc_code};
      got_data = wb_data;
      if (n == 40) check("load done", 64'h1, 64'h0);
   endtask
   function automatic logic [63:0] exp_data(input logic [5:0] opc,
      input logic [2:0] va, input logic [63:0] tv, input logic [4:0] c);
      logic [31:0] w, r;
      int b;
      w = (va[2] ^ c[3]) ? DW[63:32] : DW[31:0];
      b = int'(va[1:0] ^ {2{c[3]}});
      r = tv[31:0];
      for (int i = 0; i < 4; i++) begin
         if (opc == OPC_RIGHT && i < 4 - b) r[8*i +: 8] = w[8*(i+b) +: 8];
         if (opc == OPC_LEFT && i >= 3 - b) r[8*i +: 8] = w[8*(i-3+b) +: 8];
      end
      if (opc == OPC_UWORD) return {32'h0, w};
      return c[0] ? {{32{r[31]}}, r} : {tv[63:32], r};
   endfunction
   // access type above offset
   function automatic logic [5:0] exp_req(input logic [5:0] opc,
      input logic [2:0] va, input logic [4:0] c);
      logic [1:0] b;
      logic [2:0] o;
      b = va[1:0] ^ {2{c[3]}};
      o = va ^ {3{c[4]}};
      if (opc == OPC_RIGHT) return {3'h3 - {1'b0, b}, c[2] ? 3'h0 : o};
      if (opc == OPC_LEFT) return {1'b0, b, c[2] ? o : {o[2], 2'h0}};
      return {TYPE_WORD, o};
   endfunction
   // reserved mode is judged before alignment
   function automatic logic [3:0] exp_exc(input logic [5:0] opc,
      input logic [2:0] va, input logic [4:0] c);
      if (opc != OPC_UWORD) return {1'b0, EXC_NONE};
      if (c[1:0] == 2'b00) return {1'b1, EXC_RESV};
      if (va[1:0] != 2'b00) return {1'b1, EXC_ADDR};
      return {1'b0, EXC_NONE};
   endfunction
   // one load: tv is driven as target, fv is the value it should merge into
   task run(input logic [5:0] opc, input logic [2:0] va,
            input logic [63:0] tv, input logic [63:0] fv);
      logic [3:0] e0, e;
      issue(opc, va, tv);
      e0 = exp_exc(opc, va, ctrl);
      e  = e0;
      if (!e0[3] && fault != 3'h0) begin
         e = {1'b1, fault[2] ? EXC_REFILL : fault[1] ? EXC_INVALID : EXC_BUS};
      end
      finish();
      check("exception", 64'(e),
            64'(got_exc));
      check("written", 64'(!e[3]), 64'(got_wb));
      check("request", 64'(!e0[3]), 64'(seen));
      if (!e0[3]) begin
         // 32-bit mode forms a sign-extended word address
         check("address", (ctrl[0] ? 64'h1_0000_0FF0 : 64'h0FF0)
               + 64'(va), req.virtual_address);
         check("type offset", 64'(exp_req(opc, va, ctrl)),
               64'({req.access_type, req.offset}));
      end
      if (!e[3]) begin
         check("data", exp_data(opc, va, fv, ctrl),
               got_data);
         check("index", 64'h9, 64'(wb_index));
      end
   endtask

   // ************
   // tests
   // ************
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // watchdog well beyond the roughly 1300 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
   initial begin
      {reset_n, issue_valid, reg_wr, reg_rd, issue_instr, tgt_v} = '0;
      {reg_addr, reg_wdata, delay, fault, ctrl} = '0;
      base_v = 64'h1_0000_1000;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check("idle", 64'h0,
            64'({busy, mem_req_valid, wb_valid, exc_valid, irq}));
      reg_chk("ctrl", ADDR_CTRL, 32'(CTRL_RESET));
      reg_chk("enable", ADDR_ENABLE, 32'(EV_RESET));
      // no mode, each mode bit alone and one mix, every load kind, every byte position, slow and fast
      foreach (modes[m]) begin
         reg_write(ADDR_CTRL, 32'(modes[m]));
         ctrl = modes[m];
         foreach (opcs[o]) begin
            for (int v = 0; v < 8; v++) begin
               delay <= 4'(v);
               run(opcs[o], 3'(v), DW ^ {8{8'(v * 37)}},
                   DW ^ {8{8'(v * 37)}});
            end
         end
      end
      // memory faults, alone and together, with a stalling memory
      delay <= 4'h5;
      for (int f = 1; f < 8; f++) begin
         fault <= 3'(f);
         run(OPC_RIGHT, 3'h3, 64'h0, 64'h0);
      end
      fault <= 3'h0;
      delay <= 4'h0;
      // right part issued in the write-back cycle of the word before it
      reg_write(ADDR_CTRL, 32'h01);
      ctrl = 5'h01;
      issue(OPC_UWORD, 3'h0, 64'h0);
      repeat (2) @(posedge clk);
      run(OPC_RIGHT, 3'h1, ~DW, {32'h0, DW[31:0]});
      // sticky status, mask, clear and the interrupt level
      reg_write(ADDR_CLEAR, 32'h1F);
      reg_chk("status clear", ADDR_STATUS, 32'h0);
      run(OPC_UWORD, 3'h2, 64'h0, 64'h0);
      reg_chk("status", ADDR_STATUS, 32'h1 << EV_ADDR);
      check("masked irq", 64'h0, 64'(irq));
      reg_write(ADDR_ENABLE, 32'h1F);
      repeat (2) @(posedge clk);
      #1;
      check("irq", 64'h1, 64'(irq));
      reg_write(ADDR_STATUS, 32'h0);
      reg_chk("status ro", ADDR_STATUS, 32'h1 << EV_ADDR);
      reg_chk("clear wo", ADDR_CLEAR, 32'h0);
      reg_chk("unmapped", 4'h2, 32'h0);
      reg_chk("enable", ADDR_ENABLE, 32'h1F);
      reg_write(ADDR_CLEAR, 32'h1 << EV_ADDR);
      repeat (2) @(posedge clk);
      #1;
      check("irq low", 64'h0, 64'(irq));
      reg_chk("status low", ADDR_STATUS, 32'h0);
      results();
   end
endmodule
